// *** dv/gateway_front_panel_status_test.sv ***
// Self-checking bench for the front-panel block, random and corner cases.
// Assumes a tick of 4 cycles per ms and a 600 ms warning time.
`timescale 1ns/1ps
`include "gfps_defines.svh"

module gateway_front_panel_status_test;
  import gfps_pkg::*;
  localparam int TICK = 4;
  localparam int WMS = 600;
  logic sys_clk, rstn, reg_wr, reg_rd, fb_fault, fb_data_exchange, err_req;
  logic fg, fr, bf, gg, gr, sav, nfs, cv;
  logic [7:0] reg_addr, dip, serial_id, station_address, node_id, v8;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [3:0] err_num, sh, sl, ah, al, disp, en;
  logic [1:0] baud_sel;
  logic [4:0] f;
  logic [2:0] ef;
  logic [23:0] sw;
  logic [4:0] fbx [4] = '{5'b10010, 5'b11010, 5'b11110, 5'b01100};
  logic [4:0] gwx [4] = '{5'b10010, 5'b11010, 5'b11110, 5'b01110};
  gfps_fb_state_t fb_state;
  gfps_gw_state_t gw_state;
  int mismatches, checks_done, i;
  int unsigned seed;

  gfps_top #(.TICK_CYCLES(TICK), .WARN_MS(WMS)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_id_high_switch(sh), .serial_id_low_switch(sl),
    .station_high_switch(ah), .station_low_switch(al), .dip_switch(dip),
    .fb_state(fb_state), .gw_state(gw_state), .fb_fault(fb_fault),
    .fb_data_exchange(fb_data_exchange), .err_req(err_req), .err_num(err_num),
    .fieldbus_state_green(fg), .fieldbus_state_red(fr), .bus_fault_indicator(bf),
    .gateway_state_green(gg), .gateway_state_red(gr), .identity_select_display(disp),
    .serial_id(serial_id), .station_address(station_address),
    .station_address_valid(sav), .node_id(node_id), .baud_sel(baud_sel),
    .node_id_from_store(nfs), .config_valid(cv));
  gfps_panel_model PANEL (.sys_clk(sys_clk), .sid_hi(sh), .sid_lo(sl), .sta_hi(ah),
    .sta_lo(al), .dip_sw(dip));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic raise(input logic [3:0] n);
    @(posedge sys_clk);
    err_req <= 1'b1;
    err_num <= n;
    @(posedge sys_clk);
    err_req <= 1'b0;
  endtask
  // Bounded poll: a stuck error display ends the run instead of hanging
  task automatic wait_idle(input int n);
    for (int k = 0; k < n; k++)
    begin
      rd(`GFPS_REG_ERR, rd_v);
      if (rd_v[7:4] === 4'h1)
        return;
    end
    mismatches++;
    print_verdict();
  endtask
  task automatic reset_dut(input logic [23:0] v);
    PANEL.set_sw(v);
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(6);
  endtask
  function automatic logic [7:0] exp_node(input logic [7:0] d, input logic [7:0] nv);
    return (d[5:0] == 6'h0) ? nv : {2'h0, d[5:0]};
  endfunction
  task automatic check_cfg(input logic [23:0] v, input logic [7:0] nv);
    cmp("serial_id", v[23:16], serial_id);
    cmp("station", v[15:8], station_address);
    cmp("station_ok", v[15:8] <= 8'h7d, sav);
    cmp("node_id", exp_node(v[7:0], nv), node_id);
    cmp("baud", v[7:6], baud_sel);
    cmp("from_store", v[5:0] == 6'h0, nfs);
    cmp("cfg_valid", 1'b1, cv);
  endtask
  // Flags seen over a window: green on/off, red on/off, both lit
  task automatic led_flags(input bit gw, output logic [4:0] fo);
    logic g, r;
    fo = 5'h0;
    repeat (1700)
    begin
      @(negedge sys_clk);
      g = gw ? gg : fg;
      r = gw ? gr : fr;
      fo |= {g, !g, r, !r, g & r};
    end
  endtask
  task automatic err_show(input logic [3:0] n, output logic [2:0] fo);
    fo = 3'h0;
    repeat (2200)
    begin
      @(negedge sys_clk);
      fo |= {disp === n, disp !== n && disp !== 4'h0, gr !== 1'b1};
    end
  endtask

  initial
  begin
    {rstn, reg_wr, reg_rd, fb_fault, fb_data_exchange, err_req} = 6'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    err_num = 4'h0;
    fb_state = GFPS_FB_EXCHANGE;
    gw_state = GFPS_GW_EXCHANGE;
    seed = $urandom(32'h84322014);
    sw = {8'($urandom), 8'($urandom % 126), 2'($urandom), 6'(1 + $urandom % 63)};
    reset_dut(sw);
    check_cfg(sw, 8'h01);
    rd(`GFPS_REG_NV_NODE, rd_v);
    cmp("nv_node", 32'h1, rd_v);
    rd(`GFPS_REG_STATION, rd_v);
    cmp("station_reg", {23'h0, 1'b1, sw[15:8]}, rd_v);
    rd(`GFPS_REG_SWITCH, rd_v);
    cmp("switch_reg", {16'h0, sw[7:0], sw[23:16]}, rd_v);
    rd(`GFPS_REG_WARN_TIME, rd_v);
    cmp("warn_time", {16'h0, `GFPS_WARN_TIME_RST}, rd_v);
    rd(8'h20, rd_v);
    cmp("unmapped", 32'h0, rd_v);
    PANEL.set_sw(~sw);
    cyc(10);
    check_cfg(sw, 8'h01);
    repeat (24)
    begin
      @(posedge sys_clk);
      fb_fault <= 1'($urandom);
      fb_data_exchange <= 1'($urandom);
      cyc(1);
      cmp("bus_fault", fb_fault & !fb_data_exchange, bf);
    end
    for (i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      fb_state <= gfps_fb_state_t'(4'h1 << i);
      gw_state <= gfps_gw_state_t'(4'h1 << i);
      cyc(3);
      led_flags(1'b0, f);
      cmp("fb_led", fbx[i], f);
      led_flags(1'b1, f);
      cmp("gw_led", gwx[i], f);
    end
    @(posedge sys_clk);
    gw_state <= GFPS_GW_EXCHANGE;
    en = 4'(6 + $urandom % 10);
    raise(en);
    cyc(3);
    err_show(en, ef);
    cmp("warn_show", 3'b100, ef);
    wait_idle(400);
    cyc(2);
    cmp("warn_clear", 4'h0, disp);
    v8 = 8'($urandom);
    wr(`GFPS_REG_CTRL, 32'h7);
    wr(`GFPS_REG_LED_VAL, {24'h0, v8});
    rd(`GFPS_REG_LED_VAL, rd_v);
    cmp("led_val", {24'h0, v8}, rd_v);
    rd(`GFPS_REG_CTRL, rd_v);
    cmp("ctrl", 32'h7, rd_v);
    raise(en);
    cyc(3);
    cmp("override", v8, {disp, gr, gg, fr, fg});
    wr(`GFPS_REG_CTRL, 32'h0);
    wait_idle(1500);
    wr(`GFPS_REG_WARN_TIME, 32'h1);
    wr(`GFPS_REG_ERR, 32'hc);
    rd(`GFPS_REG_ERR, rd_v);
    cmp("user_err", 32'h8c, rd_v);
    cyc(3800);
    rd(`GFPS_REG_ERR, rd_v);
    cmp("user_hold", 32'h8c, rd_v);
    wait_idle(300);
    wr(`GFPS_REG_ERR, 32'h5);
    wr(`GFPS_REG_ERR, 32'h100);
    rd(`GFPS_REG_ERR, rd_v);
    cmp("user_clear", 4'h1, rd_v[7:4]);
    en = 4'(1 + $urandom % 5);
    raise(en);
    raise(4'h9);
    cyc(3000);
    rd(`GFPS_REG_ERR, rd_v);
    cmp("serious", {24'h0, 4'h2, en}, rd_v);
    cmp("serious_red", 1'b1, gr);
    sw = {8'($urandom), 8'h7e, 2'($urandom), 6'h0};
    reset_dut(sw);
    check_cfg(sw, 8'h01);
    rd(`GFPS_REG_ERR, rd_v);
    cmp("err_after_rst", 32'h10, rd_v);
    wr(`GFPS_REG_NV_NODE, 32'h50);
    cyc(3);
    cmp("nv_node_big", 8'h50, node_id);
    rd(`GFPS_REG_NODE, rd_v);
    cmp("node_reg", {15'h0, 1'b1, 6'h0, sw[7:6], 8'h50}, rd_v);
    print_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
endmodule

bind gfps_top gfps_top_assertions CHK (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .fb_state(fb_state), .fb_fault(fb_fault),
  .fb_data_exchange(fb_data_exchange), .err_req(err_req), .err_num(err_num),
  .fieldbus_state_green(fieldbus_state_green), .fieldbus_state_red(fieldbus_state_red),
  .bus_fault_indicator(bus_fault_indicator), .gateway_state_green(gateway_state_green),
  .gateway_state_red(gateway_state_red), .identity_select_display(identity_select_display),
  .serial_id(serial_id), .station_address(station_address),
  .station_address_valid(station_address_valid), .node_id(node_id), .baud_sel(baud_sel),
  .node_id_from_store(node_id_from_store), .config_valid(config_valid));

// *** dv/gfps_panel_model.sv ***
// Front-panel model: the rotary and DIP switches seen by the gateway.
// Assumes the bench moves switches around a reset, and once after capture to check that the move is ignored.
`timescale 1ns/1ps

module gfps_panel_model
(
  // Clock
  input wire logic sys_clk,
  // Switch pins
  output logic [3:0] sid_hi,
  output logic [3:0] sid_lo,
  output logic [3:0] sta_hi,
  output logic [3:0] sta_lo,
  output logic [7:0] dip_sw
);
  initial
  begin
    {sid_hi, sid_lo, sta_hi, sta_lo, dip_sw} = 24'h0;
  end
  // Contacts are static levels; no bounce modelled
  task automatic set_sw(input logic [23:0] v);
    @(posedge sys_clk);
    {sid_hi, sid_lo, sta_hi, sta_lo, dip_sw} <= v;
  endtask
endmodule

// *** dv/gfps_top_assertions.sv ***
// Checker for the front-panel block, bound to the top module's ports.
// Assumes register writes are visible at the ports and LEDs lag by one edge.
`timescale 1ns/1ps
`include "gfps_defines.svh"

module gfps_top_assertions
  import gfps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register writes
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // State sources
  input wire gfps_pkg::gfps_fb_state_t fb_state,
  input wire logic fb_fault,
  input wire logic fb_data_exchange,
  input wire logic err_req,
  input wire logic [3:0] err_num,
  // LEDs
  input wire logic fieldbus_state_green,
  input wire logic fieldbus_state_red,
  input wire logic bus_fault_indicator,
  input wire logic gateway_state_green,
  input wire logic gateway_state_red,
  input wire logic [3:0] identity_select_display,
  // Captured configuration
  input wire logic [7:0] serial_id,
  input wire logic [7:0] station_address,
  input wire logic station_address_valid,
  input wire logic [7:0] node_id,
  input wire logic [1:0] baud_sel,
  input wire logic node_id_from_store,
  input wire logic config_valid
);
  logic [2:0] ov_r;
  logic [7:0] val_r;
  logic ctrl_wr;
  // Shadow of the override registers, since the LEDs depend on them
  assign ctrl_wr = reg_wr && reg_addr == `GFPS_REG_CTRL;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      ov_r <= 3'h0;
    else if (ctrl_wr)
      ov_r <= reg_wdata[2:0];
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      val_r <= 8'h00;
    else if (reg_wr && reg_addr == `GFPS_REG_LED_VAL)
      val_r <= reg_wdata[7:0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_fault_off: assert property (fb_data_exchange |=> !bus_fault_indicator)
    else $error("bus fault lit during data exchange");
  chk_fault_on: assert property (fb_fault && !fb_data_exchange |=> bus_fault_indicator)
    else $error("bus fault not shown");
  chk_switch_hold: assert property (config_valid && $past(config_valid) |->
    $stable(serial_id) && $stable(station_address) && $stable(baud_sel))
    else $error("captured switch value moved");
  chk_cfg_stays: assert property (config_valid |=> config_valid)
    else $error("capture flag dropped");
  chk_station_range: assert property (config_valid |->
    station_address_valid == (station_address <= `GFPS_STATION_MAX))
    else $error("station valid flag wrong");
  chk_node_source: assert property (config_valid && !node_id_from_store |->
    node_id != 8'h00 && node_id[7:6] == 2'h0)
    else $error("switch node id out of range");
  chk_fb_red: assert property (fb_state == GFPS_FB_ERROR && !ov_r[0] && !ctrl_wr |=>
    fieldbus_state_red && !fieldbus_state_green)
    else $error("fieldbus error not steady red");
  chk_fb_green: assert property (fb_state == GFPS_FB_EXCHANGE && !ov_r[0] && !ctrl_wr |=>
    fieldbus_state_green && !fieldbus_state_red)
    else $error("fieldbus exchange not steady green");
  chk_serious_red: assert property (err_req && err_num != 4'h0 &&
    err_num <= `GFPS_SERIOUS_MAX && !ov_r[1] && !ctrl_wr ##1 !ctrl_wr |=> gateway_state_red)
    else $error("serious error not shown red");
  chk_err_ovr: assert property ($past(ov_r[2]) |->
    identity_select_display == $past(val_r[7:4]))
    else $error("error LEDs ignore override");
  chk_gw_ovr: assert property ($past(ov_r[1]) |->
    {gateway_state_red, gateway_state_green} == $past(val_r[3:2]))
    else $error("gateway LED ignores override");

  cov_capture: cover property ($rose(config_valid));
  cov_warn: cover property (err_req && err_num > `GFPS_SERIOUS_MAX);
  cov_ovr: cover property (ov_r == 3'h7);
endmodule

// *** rtl/gfps_defines.svh ***
// Timing counts, register offsets and reset values of the front-panel block.
// Assumes a single system clock; only the tick period is turned into a cycle count here, other times stay in ms.
`ifndef GFPS_DEFINES_SVH
`define GFPS_DEFINES_SVH

`define GFPS_CLK_HZ 25000000
`define GFPS_TICK_US 1000
`define GFPS_TICK_CYCLES ((`GFPS_TICK_US * (`GFPS_CLK_HZ / 1000000)))

`define GFPS_STATE_HALF_MS 200
`define GFPS_ERR_HALF_MS 250
`define GFPS_USER_HALF_MS 1000
`define GFPS_WARN_MS 60000
`define GFPS_MS_PER_S 1000

`define GFPS_REG_CTRL 8'h00
`define GFPS_REG_LED_VAL 8'h04
`define GFPS_REG_ERR 8'h08
`define GFPS_REG_NV_NODE 8'h0c
`define GFPS_REG_WARN_TIME 8'h10
`define GFPS_REG_STATION 8'h14
`define GFPS_REG_SWITCH 8'h18
`define GFPS_REG_NODE 8'h1c

`define GFPS_NV_NODE_RST 8'h01
`define GFPS_WARN_TIME_RST 16'h000a
`define GFPS_STATION_MAX 8'h7d
`define GFPS_SERIOUS_MAX 4'h5

`define GFPS_DIP_NODE_LSB 0
`define GFPS_DIP_NODE_W 6
`define GFPS_DIP_BAUD_LSB 6
`define GFPS_DIP_BAUD_W 2

`define GFPS_ERR_CLEAR_BIT 8
`define GFPS_STATION_VALID_BIT 8
`define GFPS_NODE_SRC_BIT 16

`endif

// *** rtl/gfps_pkg.sv ***
// Types shared by the front-panel block and its users.
// Assumes the state sources run on the same clock as this block.
package gfps_pkg;

  typedef enum logic [3:0] {
    GFPS_FB_EXCHANGE = 4'b0001,
    GFPS_FB_WAIT_CFG = 4'b0010,
    GFPS_FB_WAIT_PRM = 4'b0100,
    GFPS_FB_ERROR = 4'b1000
  } gfps_fb_state_t;

  typedef enum logic [3:0] {
    GFPS_GW_EXCHANGE = 4'b0001,
    GFPS_GW_CONN_OK = 4'b0010,
    GFPS_GW_NO_EXCH = 4'b0100,
    GFPS_GW_CONFIG = 4'b1000
  } gfps_gw_state_t;

  typedef enum logic [3:0] {
    GFPS_ERR_IDLE = 4'b0001,
    GFPS_ERR_SERIOUS = 4'b0010,
    GFPS_ERR_WARN = 4'b0100,
    GFPS_ERR_USER = 4'b1000
  } gfps_err_state_t;

endpackage

// *** rtl/gfps_switch_capture.sv ***
// Synchronises switch pins and captures them once after reset release.
// Assumes switches are static around power-up; later moves are ignored.
`timescale 1ns/1ps

module gfps_switch_capture
#(
  parameter int W = 24
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Switch pins
  input wire logic [W-1:0] sw_pins,
  // Captured values
  output logic [W-1:0] sw_held,
  output logic done
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [1:0] fill_r;

  // Refused at elaboration
  if (W < 1)
  begin : g_bad_w
    $error("W must be at least 1");
  end

  // Two stages per bit; the first is read by nothing else
  generate
    for (genvar i = 0; i < W; i++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= sw_pins[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  // Wait for the synchroniser to fill before the one-time capture
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fill_r <= 2'h0;
    else if (fill_r != 2'h2)
      fill_r <= fill_r + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sw_held <= '0;
      done <= 1'b0;
    end
    else if (!done && fill_r == 2'h2)
    begin
      sw_held <= sync_r;
      done <= 1'b1;
    end
  end

endmodule

// *** rtl/gfps_tick_gen.sv ***
// Millisecond enable pulse derived from the system clock.
// Assumes TICK_CYCLES is shortened in simulation to keep runs quick.
`timescale 1ns/1ps
`include "gfps_defines.svh"

module gfps_tick_gen
#(
  parameter int TICK_CYCLES = `GFPS_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Enable out
  output logic ms_tick
);

  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [CW-1:0] cnt_r;

  // Refused at elaboration
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (cnt_r == CW'(TICK_CYCLES - 1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + CW'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ms_tick <= 1'b0;
    else
      ms_tick <= (cnt_r == CW'(TICK_CYCLES - 1));
  end

endmodule

// *** rtl/gfps_top.sv ***
// Front-panel status LEDs and configuration switch capture of the gateway.
// Assumes state sources share sys_clk; switches arrive as raw pins.
`timescale 1ns/1ps
`include "gfps_defines.svh"

module gfps_top
#(
  parameter int TICK_CYCLES = `GFPS_TICK_CYCLES,
  parameter int WARN_MS = `GFPS_WARN_MS
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Switch pins
  input wire logic [3:0] serial_id_high_switch,
  input wire logic [3:0] serial_id_low_switch,
  input wire logic [3:0] station_high_switch,
  input wire logic [3:0] station_low_switch,
  input wire logic [7:0] dip_switch,
  // Internal state sources
  input wire gfps_pkg::gfps_fb_state_t fb_state,
  input wire gfps_pkg::gfps_gw_state_t gw_state,
  input wire logic fb_fault,
  input wire logic fb_data_exchange,
  input wire logic err_req,
  input wire logic [3:0] err_num,
  // Panel LEDs
  output logic fieldbus_state_green,
  output logic fieldbus_state_red,
  output logic bus_fault_indicator,
  output logic gateway_state_green,
  output logic gateway_state_red,
  output logic [3:0] identity_select_display,
  // Captured configuration
  output logic [7:0] serial_id,
  output logic [7:0] station_address,
  output logic station_address_valid,
  output logic [7:0] node_id,
  output logic [1:0] baud_sel,
  output logic node_id_from_store,
  output logic config_valid
);
  import gfps_pkg::*;

  localparam int NPH = 3;
  localparam int HALF_MS [NPH] = '{`GFPS_STATE_HALF_MS, `GFPS_ERR_HALF_MS, `GFPS_USER_HALF_MS};

  // Refused at elaboration
  if (WARN_MS < 1 || TICK_CYCLES < 1)
  begin : g_bad_param
    $error("WARN_MS and TICK_CYCLES must be at least 1");
  end

  function automatic logic is_serious(input logic [3:0] num);
    is_serious = (num != 4'h0) && (num <= `GFPS_SERIOUS_MAX);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic ms_tick;
  logic [NPH-1:0] phase;
  logic [23:0] sw_held;
  logic [7:0] dip_held;
  logic cap_done;
  logic [2:0] ovr_en_r;
  logic [7:0] led_val_r;
  logic [7:0] nv_node_r;
  logic [15:0] warn_time_r;
  gfps_err_state_t err_state_r;
  logic [3:0] err_num_r;
  logic [31:0] hold_ms_r;
  logic user_set;
  logic user_clr;
  logic [31:0] user_ms;
  logic err_shown;
  logic [5:0] dip_node;

  gfps_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ms_tick(ms_tick)
  );

  // One capture of every switch after reset
  gfps_switch_capture #(
    .W(24)
  ) u_cap (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sw_pins({dip_switch, station_high_switch, station_low_switch,
              serial_id_high_switch, serial_id_low_switch}),
    .sw_held(sw_held),
    .done(cap_done)
  );

  assign dip_held = sw_held[23:16];
  assign dip_node = dip_held[`GFPS_DIP_NODE_LSB +: `GFPS_DIP_NODE_W];

  // Blink phases: gateway/bus state, system error, user error
  generate
    for (genvar i = 0; i < NPH; i++)
    begin : g_phase
      logic [9:0] cnt_r;
      logic ph_r;
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          cnt_r <= 10'h000;
          ph_r <= 1'b0;
        end
        else if (ms_tick)
        begin
          if (cnt_r == 10'(HALF_MS[i] - 1))
          begin
            cnt_r <= 10'h000;
            ph_r <= ~ph_r;
          end
          else
            cnt_r <= cnt_r + 10'h001;
        end
      end
      assign phase[i] = ph_r;
    end
  endgenerate

  // Captured configuration outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_id <= 8'h00;
      station_address <= 8'h00;
      station_address_valid <= 1'b0;
      node_id <= 8'h00;
      baud_sel <= 2'h0;
      node_id_from_store <= 1'b0;
      config_valid <= 1'b0;
    end
    else
    begin
      serial_id <= sw_held[7:0];
      station_address <= sw_held[15:8];
      station_address_valid <= cap_done && (sw_held[15:8] <= `GFPS_STATION_MAX);
      baud_sel <= dip_held[`GFPS_DIP_BAUD_LSB +: `GFPS_DIP_BAUD_W];
      // Zero on the DIP means the stored ID is used, which may exceed 63
      node_id_from_store <= (dip_node == 6'h00);
      node_id <= (dip_node == 6'h00) ? nv_node_r : {2'h0, dip_node};
      config_valid <= cap_done;
    end
  end

  // Software writes
  assign user_set = reg_wr && hit(reg_addr, `GFPS_REG_ERR) && reg_wdata[3:0] != 4'h0;
  assign user_clr = reg_wr && hit(reg_addr, `GFPS_REG_ERR) && reg_wdata[`GFPS_ERR_CLEAR_BIT];
  assign user_ms = 32'(warn_time_r) * 32'(`GFPS_MS_PER_S);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ovr_en_r <= 3'h0;
      led_val_r <= 8'h00;
      nv_node_r <= `GFPS_NV_NODE_RST;
      warn_time_r <= `GFPS_WARN_TIME_RST;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, `GFPS_REG_CTRL))
        ovr_en_r <= reg_wdata[2:0];
      if (hit(reg_addr, `GFPS_REG_LED_VAL))
        led_val_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GFPS_REG_NV_NODE))
        nv_node_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GFPS_REG_WARN_TIME))
        warn_time_r <= reg_wdata[15:0];
    end
  end

  // Error display state; internal reports win over a software error
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      err_state_r <= GFPS_ERR_IDLE;
      err_num_r <= 4'h0;
      hold_ms_r <= 32'h0;
    end
    else
    begin
      case (err_state_r)
        GFPS_ERR_SERIOUS:
        begin
          // Held until the next reset
          err_state_r <= GFPS_ERR_SERIOUS;
        end
        GFPS_ERR_IDLE, GFPS_ERR_WARN, GFPS_ERR_USER:
        begin
          if (err_req && err_num != 4'h0)
          begin
            err_num_r <= err_num;
            hold_ms_r <= 32'(WARN_MS);
            err_state_r <= is_serious(err_num) ? GFPS_ERR_SERIOUS : GFPS_ERR_WARN;
          end
          else if (user_set)
          begin
            err_num_r <= reg_wdata[3:0];
            hold_ms_r <= user_ms;
            err_state_r <= GFPS_ERR_USER;
          end
          else if (user_clr && err_state_r == GFPS_ERR_USER)
            err_state_r <= GFPS_ERR_IDLE;
          else if (err_state_r != GFPS_ERR_IDLE && ms_tick)
          begin
            // Automatic clear when the display time runs out
            if (hold_ms_r <= 32'h1)
              err_state_r <= GFPS_ERR_IDLE;
            else
              hold_ms_r <= hold_ms_r - 32'h1;
          end
        end
        default:
          err_state_r <= GFPS_ERR_IDLE;
      endcase
    end
  end

  assign err_shown = (err_state_r != GFPS_ERR_IDLE);

  // Fieldbus state and bus fault LEDs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fieldbus_state_green <= 1'b0;
      fieldbus_state_red <= 1'b0;
      bus_fault_indicator <= 1'b0;
    end
    else
    begin
      bus_fault_indicator <= fb_fault && !fb_data_exchange;
      if (ovr_en_r[0])
      begin
        fieldbus_state_green <= led_val_r[0];
        fieldbus_state_red <= led_val_r[1];
      end
      else
      begin
        case (fb_state)
          GFPS_FB_EXCHANGE:
          begin
            fieldbus_state_green <= 1'b1;
            fieldbus_state_red <= 1'b0;
          end
          GFPS_FB_WAIT_CFG:
          begin
            fieldbus_state_green <= phase[0];
            fieldbus_state_red <= 1'b0;
          end
          GFPS_FB_WAIT_PRM:
          begin
            fieldbus_state_green <= phase[0];
            fieldbus_state_red <= ~phase[0];
          end
          default:
          begin
            fieldbus_state_green <= 1'b0;
            fieldbus_state_red <= 1'b1;
          end
        endcase
      end
    end
  end

  // Gateway state LED; an active error shows steady red
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gateway_state_green <= 1'b0;
      gateway_state_red <= 1'b0;
    end
    else if (ovr_en_r[1])
    begin
      gateway_state_green <= led_val_r[2];
      gateway_state_red <= led_val_r[3];
    end
    else if (err_shown)
    begin
      gateway_state_green <= 1'b0;
      gateway_state_red <= 1'b1;
    end
    else
    begin
      case (gw_state)
        GFPS_GW_EXCHANGE:
        begin
          gateway_state_green <= 1'b1;
          gateway_state_red <= 1'b0;
        end
        GFPS_GW_CONN_OK:
        begin
          gateway_state_green <= phase[0];
          gateway_state_red <= 1'b0;
        end
        GFPS_GW_NO_EXCH:
        begin
          gateway_state_green <= phase[0];
          gateway_state_red <= ~phase[0];
        end
        default:
        begin
          gateway_state_green <= 1'b0;
          gateway_state_red <= phase[0];
        end
      endcase
    end
  end

  // Error number LEDs; user errors flash slower
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      identity_select_display <= 4'h0;
    else if (ovr_en_r[2])
      identity_select_display <= led_val_r[7:4];
    else if (err_state_r == GFPS_ERR_USER)
      identity_select_display <= phase[2] ? err_num_r : 4'h0;
    else if (err_shown)
      identity_select_display <= phase[1] ? err_num_r : 4'h0;
    else
      identity_select_display <= 4'h0;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else if (!reg_rd)
      reg_rdata <= 32'h0;
    else
    begin
      case (reg_addr)
        `GFPS_REG_CTRL: reg_rdata <= {29'h0, ovr_en_r};
        `GFPS_REG_LED_VAL: reg_rdata <= {24'h0, led_val_r};
        `GFPS_REG_ERR: reg_rdata <= {24'h0, err_state_r, err_num_r};
        `GFPS_REG_NV_NODE: reg_rdata <= {24'h0, nv_node_r};
        `GFPS_REG_WARN_TIME: reg_rdata <= {16'h0, warn_time_r};
        `GFPS_REG_STATION: reg_rdata <= {23'h0, station_address_valid, station_address};
        `GFPS_REG_SWITCH: reg_rdata <= {16'h0, dip_held, serial_id};
        `GFPS_REG_NODE: reg_rdata <= {15'h0, node_id_from_store, 6'h0, baud_sel, node_id};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

endmodule
